// ---- dv/mtmp_phy_model.sv ----
// Purpose: Far side transceiver: transmit clock and management replies
// Assumes: Transmit clock runs free as a reference
// Notes:   Read reply data is the parity of the bit index
`timescale 1ns/1ps
`default_nettype none
module mtmp_phy_model #(
   parameter int HALF = 20   // Half period in ns, 25 MHz
)(
   output logic     tx_clk_o,  // Transmit clock
   input wire logic mdc_i,     // Management clock
   input wire logic mdio_i,    // Resolved data line
   output logic     mdio_o,    // Our data bit
   output logic     oe_o,      // We drive the line
   input wire logic [3:0] txd_i,     // Nibble from the device
   input wire logic       tx_en_i,   // Enable from the device
   input wire logic       tx_er_i,   // Error from the device
   output logic     [3:0] nib_cnt_o, // Nibbles taken in the current frame
   output logic     [3:0] nib_o,     // Last nibble taken
   output logic           abort_o    // Frame turned into ABORT symbols
);
   int         ones = 0;
   int         idx  = -1;
   logic [1:0] op   = 2'h0;
   logic       en_q = 1'b0;
   initial begin
      tx_clk_o  = 1'b0;
      nib_cnt_o = 4'h0;
      nib_o     = 4'h0;
      abort_o   = 1'b0;
      forever #HALF tx_clk_o = ~tx_clk_o;
   end
   // Frame tracker, sampled on the management clock rise
   always @(posedge mdc_i) begin
      if (idx < 0) begin
         if (ones >= 32 && !mdio_i) idx = 1;
      end else begin
         if (idx == 2) op[1] = mdio_i;
         if (idx == 3) op[0] = mdio_i;
         idx = (idx == 31) ? -1 : idx + 1;
      end
      ones = mdio_i ? ones + 1 : 0;
   end
   // Nibble sink: enable and data taken together on our own clock rise
   always @(posedge tx_clk_o) begin
      en_q <= tx_en_i;
      if (tx_en_i) begin
         nib_o     <= txd_i;
         nib_cnt_o <= en_q ? nib_cnt_o + 4'h1 : 4'h1;
         // One errored nibble turns the rest of the frame into ABORT symbols
         abort_o   <= (en_q & abort_o) | tx_er_i;
      end
   end
   // Drive only from the second turnaround bit of a read
   assign oe_o   = (op == 2'h2) && (idx >= 15);
   assign mdio_o = (idx > 15) && idx[0];
endmodule
`default_nettype wire

// ---- dv/mtmp_props.sv ----
// Purpose: Port level checks of the nibble transmit and management pins
// Assumes: Single clk_i domain, sync reset high
// Notes:   Bound into mtmp_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module mtmp_props
   import mtmp_pkg::*;
#(
   parameter int W = NIB_W   // Nibble width
)(
   input wire logic clk_i, rst_i, tx_valid_i, tx_last_i, tx_code_err_i, tx_ready_o,
   input wire logic [W-1:0] tx_data_i, mii_txd_o,
   input wire logic mii_tx_en_o, tx_abort_flag_out, carrier_present_in, carrier_o,
   input wire logic sw_mdc_i, mii_mdc_o, mii_mdio_i, mdio_rd_bit_o, mii_mdio_oe_o,
   input wire logic mdio_read_phase_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic last_ff;   // Frame already closed by last nibble or underrun
   // Underrun closes the frame just like a last nibble
   always_ff @(posedge clk_i) begin
      if (rst_i) last_ff <= 1'b1;
      else if (tx_ready_o) last_ff <= tx_valid_i ? tx_last_i : 1'b1;
   end
   sequence s_take; tx_ready_o && tx_valid_i; endsequence
   sequence s_gap; tx_ready_o && !tx_valid_i && mii_tx_en_o; endsequence
   AST_TXD_HOLD: assert property ($changed(mii_txd_o) |-> $past(tx_ready_o))
      else $error("nibble moved without a transmit clock rise");
   AST_EN_HOLD: assert property ($changed(mii_tx_en_o) |-> $past(tx_ready_o))
      else $error("enable moved without a transmit clock rise");
   AST_TAKE: assert property (s_take |=> mii_tx_en_o && mii_txd_o == $past(tx_data_i))
      else $error("taken nibble not launched");
   AST_ER_IN_FRAME: assert property (tx_abort_flag_out |-> mii_tx_en_o)
      else $error("error flag outside a frame");
   AST_CODE_ERR: assert property (s_take ##0 tx_code_err_i |=> tx_abort_flag_out)
      else $error("coding error not flagged");
   AST_UNDERRUN: assert property (s_gap ##0 !last_ff |=> tx_abort_flag_out && mii_txd_o == NIB_IDLE)
      else $error("underrun not flagged");
   AST_FRAME_END: assert property (s_gap ##0 last_ff |=> !mii_tx_en_o)
      else $error("enable kept after frame end");
   AST_MDC_SAMPLE: assert property ($rose(sw_mdc_i) |=> mii_mdc_o && mdio_rd_bit_o == $past(mii_mdio_i))
      else $error("management clock or read bit wrong");
   AST_RELEASE: assert property (mdio_read_phase_o |-> !mii_mdio_oe_o)
      else $error("data line driven while the far side owns it");
   AST_CARRIER: assert property (!$past(rst_i) |-> carrier_o == $past(carrier_present_in))
      else $error("carrier copy wrong");
endmodule
`default_nettype wire

// ---- dv/mtmp_top_tb.sv ----
// Purpose: Self checking bench for the transmit and management port
// Assumes: Transmit clock at 25 MHz from the far side model
// Notes:   Data line resolves with a pull-up when nobody drives
`timescale 1ns/1ps
`default_nettype none
module mtmp_top_tb;
   import mtmp_pkg::*;
   logic clk_i, rst_i, tx_valid_i, tx_last_i, tx_code_err_i, tx_ready_o, tx_underrun_o;
   logic mii_tx_clk_i, mii_tx_en_o, tx_abort_flag_out, carrier_present_in, mii_col_i;
   logic carrier_o, collision_o, sw_mdc_i, sw_mdio_i, sw_mdio_oe_i, mii_mdc_o, mii_mdio_i;
   logic mii_mdio_o, mii_mdio_oe_o, mdio_rd_bit_o, mdio_read_phase_o, phy_o, phy_oe;
   logic [3:0] tx_data_i, mii_txd_o;
   logic [3:0] phy_cnt, phy_nib;
   logic       phy_abort;
   int failures = 0;
   int samples_checked = 0;
   assign mii_mdio_i = mii_mdio_oe_o ? mii_mdio_o : (phy_oe ? phy_o : 1'b1);
   mtmp_top #(.W(4)) DUT (.clk_i, .rst_i, .tx_valid_i, .tx_data_i, .tx_last_i,
      .tx_code_err_i, .tx_ready_o, .tx_underrun_o, .mii_tx_clk_i, .mii_txd_o,
      .mii_tx_en_o, .tx_abort_flag_out, .carrier_present_in, .mii_col_i, .carrier_o,
      .collision_o, .sw_mdc_i, .sw_mdio_i, .sw_mdio_oe_i, .mii_mdc_o, .mii_mdio_i,
      .mii_mdio_o, .mii_mdio_oe_o, .mdio_rd_bit_o, .mdio_read_phase_o);
   mtmp_phy_model u_phy (.tx_clk_o(mii_tx_clk_i), .mdc_i(mii_mdc_o), .mdio_i(mii_mdio_i),
      .mdio_o(phy_o), .oe_o(phy_oe), .txd_i(mii_txd_o), .tx_en_i(mii_tx_en_o),
      .tx_er_i(tx_abort_flag_out), .nib_cnt_o(phy_cnt), .nib_o(phy_nib), .abort_o(phy_abort));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic give_verdict();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Present a nibble, wait for its launch to settle
   task automatic send(input logic [3:0] d, input logic l, input logic e, input logic v);
      int k;
      k = 0;
      tx_valid_i = v; tx_data_i = d; tx_last_i = l; tx_code_err_i = e;
      while (tx_ready_o !== 1'b1) begin
         @(negedge clk_i);
         k++;
         if (k > 40) begin failures++; give_verdict(); end
      end
      repeat (2) @(negedge clk_i);
   endtask
   // Back to back frame with a coding error near its end
   task automatic t_frame();
      for (int i = 0; i < 6; i++) begin
         send(4'(i * 3 + 1), i == 5, i == 4, 1'b1);
         chk("txd", mii_txd_o, 4'(i * 3 + 1));
         chk("en", {3'h0, mii_tx_en_o}, 4'h1);
         chk("er", {3'h0, tx_abort_flag_out}, {3'h0, i == 4});
      end
      send(4'h0, 1'b0, 1'b0, 1'b0);
      chk("en_end", {3'h0, mii_tx_en_o}, 4'h0);
      chk("phy_cnt", phy_cnt, 4'h6);
      chk("phy_nib", phy_nib, 4'(5 * 3 + 1));
      chk("phy_abort", {3'h0, phy_abort}, 4'h1);
   endtask
   // Source starves mid frame
   task automatic t_under();
      send(4'h7, 1'b0, 1'b0, 1'b1);
      send(4'h0, 1'b0, 1'b0, 1'b0);
      chk("ur_nib", mii_txd_o, NIB_IDLE);
      chk("ur_flag", {1'b0, mii_tx_en_o, tx_abort_flag_out, tx_underrun_o}, 4'h7);
      send(4'h0, 1'b0, 1'b0, 1'b0);
      chk("ur_end", {1'b0, mii_tx_en_o, tx_abort_flag_out, tx_underrun_o}, 4'h0);
      chk("phy_ur", {phy_cnt[2:0], phy_abort}, 4'h5);
   endtask
   // Read or write frame; software keeps asking to drive after turnaround
   task automatic t_mgmt(input logic rd);
      int         k;
      logic       b;
      logic [3:0] md;
      for (int i = 0; i < 64; i++) begin
         k = i - 32;
         b = !(k == 0 || k == (rd ? 3 : 2));
         sw_mdio_i = b; sw_mdio_oe_i = 1'b1; sw_mdc_i = 1'b0;
         repeat (3) @(negedge clk_i);
         md = {1'b0, mdio_read_phase_o, mii_mdio_oe_o, mii_mdio_o};
         if (k < 14 || !rd) chk("md_out", md, {3'h1, b});
         else chk("md_oe", {md[3:1], 1'b0}, 4'h4);
         sw_mdc_i = 1'b1;
         repeat (3) @(negedge clk_i);
         chk("mdc", {3'h0, mii_mdc_o}, 4'h1);
         if (rd && k > 15) chk("rd_bit", {3'h0, mdio_rd_bit_o}, {3'h0, k[0]});
      end
      sw_mdio_oe_i = 1'b0;
   endtask
   task automatic t_line();
      carrier_present_in = 1'b1; mii_col_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("crs_col", {2'h0, carrier_o, collision_o}, 4'h3);
      carrier_present_in = 1'b0; mii_col_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("crs_col", {2'h0, carrier_o, collision_o}, 4'h0);
   endtask
   initial begin
      rst_i = 1'b1; tx_valid_i = 1'b0; tx_data_i = 4'h0; tx_last_i = 1'b0;
      tx_code_err_i = 1'b0; carrier_present_in = 1'b0; mii_col_i = 1'b0;
      sw_mdc_i = 1'b0; sw_mdio_i = 1'b1; sw_mdio_oe_i = 1'b0;
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      t_frame();
      t_under();
      t_mgmt(1'b1);
      t_mgmt(1'b0);
      t_line();
      give_verdict();
   end
endmodule
bind mtmp_top mtmp_props #(.W(W)) u_props (.clk_i, .rst_i, .tx_valid_i, .tx_last_i,
   .tx_code_err_i, .tx_ready_o, .tx_data_i, .mii_txd_o, .mii_tx_en_o, .tx_abort_flag_out,
   .carrier_present_in, .carrier_o, .sw_mdc_i, .mii_mdc_o, .mii_mdio_i, .mdio_rd_bit_o,
   .mii_mdio_oe_o, .mdio_read_phase_o);
`default_nettype wire

// ---- logic/mtmp_mgmt.sv ----
// Purpose: Software paced management clock and data line engine
// Assumes: Software toggles the clock level slowly against clk_i
// Notes:   Follows the frame to release the line during read replies
`timescale 1ns/1ps
`default_nettype none
module mtmp_mgmt
   import mtmp_pkg::*;
(
   input  wire logic   clk_i,     // System clock
   input  wire logic   rst_i,     // Synchronous reset, high
   mtmp_mgmt_if.engine m          // Software and pin side
);

   typedef struct packed {
      logic       mdc_q;      // Last software clock level
      logic [5:0] pre_cnt;    // Preamble ones seen
      logic [4:0] bit_cnt;    // Bit index inside frame
      logic       in_frame;   // Frame under way
      logic [1:0] op;         // Captured opcode
      logic       rd;         // Captured data bit
      logic       mdc;        // Clock to pin
      logic       mdio;       // Data to pin
      logic       oe;         // Drive enable to pin
   } mtmp_mgmt_st_t;

   mtmp_mgmt_st_t st_ff;
   mtmp_mgmt_st_t nxt_st;
   logic          rise;
   logic          rd_ph;

   // ----------------------------------------------------------------
   // Frame tracking and pin drive
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      rise   = m.sw_mdc & ~st_ff.mdc_q;
      nxt_st.mdc_q = m.sw_mdc;
      // Clock edges come only from software, no divider
      nxt_st.mdc = m.sw_mdc;                                 // RULE_08
      if (rise) begin
         nxt_st.rd = m.pin_in;                               // RULE_09
         if (!st_ff.in_frame) begin
            if (m.sw_oe && m.sw_mdio) begin
               if (st_ff.pre_cnt != PRE_LEN) begin
                  nxt_st.pre_cnt = st_ff.pre_cnt + 6'h01;
               end
            end else if (m.sw_oe && st_ff.pre_cnt == PRE_LEN) begin
               nxt_st.in_frame = 1'b1;
               nxt_st.bit_cnt  = 5'h01;
               nxt_st.pre_cnt  = 6'h00;
            end else begin
               nxt_st.pre_cnt = 6'h00;
            end
         end else begin
            if (st_ff.bit_cnt == OP_HI_BIT) begin
               nxt_st.op[1] = m.sw_mdio;
            end
            if (st_ff.bit_cnt == OP_LO_BIT) begin
               nxt_st.op[0] = m.sw_mdio;
            end
            if (st_ff.bit_cnt == FRAME_LAST) begin
               nxt_st.in_frame = 1'b0;
            end
            nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
         end
      end
      // Hold off our drive once the PHY owns a read reply, even if
      // software forgets, so the line is never fought over
      rd_ph = nxt_st.in_frame && nxt_st.op == OP_READ
              && nxt_st.bit_cnt >= TA_FIRST_BIT;             // RULE_12
      nxt_st.mdio = m.sw_mdio;
      nxt_st.oe   = m.sw_oe & ~rd_ph;                        // RULE_12
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Registered answers
   assign m.mdc        = st_ff.mdc;
   assign m.mdio       = st_ff.mdio;
   assign m.mdio_oe    = st_ff.oe;
   assign m.rd_bit     = st_ff.rd;
   assign m.read_phase = st_ff.in_frame && st_ff.op == OP_READ
                         && st_ff.bit_cnt >= TA_FIRST_BIT;

endmodule
`default_nettype wire

// ---- logic/mtmp_mgmt_if.sv ----
// Purpose: Carries software management pin requests to the engine
// Assumes: Single clock domain
// Notes:   Top drives the software side, engine answers
`timescale 1ns/1ps
`default_nettype none
interface mtmp_mgmt_if;
   logic sw_mdc;        // Software clock level
   logic sw_mdio;       // Software data bit
   logic sw_oe;         // Software wants to drive data
   logic pin_in;        // Data line as seen at the pin
   logic mdc;           // Registered clock to pin
   logic mdio;          // Registered data to pin
   logic mdio_oe;       // Registered drive enable
   logic rd_bit;        // Bit caught at last clock rise
   logic read_phase;    // PHY owns the line now

   modport host (output sw_mdc, sw_mdio, sw_oe, pin_in,
                 input  mdc, mdio, mdio_oe, rd_bit, read_phase);
   modport engine (input  sw_mdc, sw_mdio, sw_oe, pin_in,
                   output mdc, mdio, mdio_oe, rd_bit, read_phase);
endinterface
`default_nettype wire

// ---- logic/mtmp_pkg.sv ----
// Purpose: Shared constants for the nibble transmit and management port
// Assumes: One 100 MHz system clock; PHY clocks arrive as sampled inputs
// Notes:   Clause 22 frame figures are used by the management engine
`default_nettype none
package mtmp_pkg;

   // ----------------------------------------------------------------
   // Data path
   // ----------------------------------------------------------------
   localparam int         NIB_W         = 4;         // Transmit nibble width
   localparam logic [3:0] NIB_IDLE      = 4'h0;      // Nibble shown outside frames
   localparam logic       BIT_RST       = 1'b0;      // Reset level of single-bit flops

   // ----------------------------------------------------------------
   // Management frame layout
   // ----------------------------------------------------------------
   localparam logic [5:0] PRE_LEN       = 6'h20;     // Preamble ones before start
   localparam logic [4:0] OP_HI_BIT     = 5'h02;     // Bit index of opcode high bit
   localparam logic [4:0] OP_LO_BIT     = 5'h03;     // Bit index of opcode low bit
   localparam logic [4:0] TA_FIRST_BIT  = 5'h0E;     // First turnaround bit index
   localparam logic [4:0] FRAME_LAST    = 5'h1F;     // Last bit index of a frame
   localparam logic [1:0] OP_READ       = 2'h2;      // Read opcode

   // Transmit states, Gray along idle -> send -> idle
   typedef enum logic [0:0] {
      MTMP_IDLE = 1'b0,
      MTMP_SEND = 1'b1
   } mtmp_tx_state_t;

endpackage
`default_nettype wire

// ---- logic/mtmp_top.sv ----
// Purpose: Nibble transmit path and management pins toward a PHY
// Assumes: PHY transmit clock is far slower than clk_i and sampled
// Notes:   Data launches after each sampled rise of the PHY clock
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01 - PHY supplies transmit clock, 25 or 2.5 MHz
// RULE_02 - One nibble per transmit clock while enabled
// RULE_03 - Nibble changes only with transmit clock
// RULE_04 - Enable spans first to last nibble, gapless
// RULE_05 - PHY samples enable and data together
// RULE_06 - Error flag on coding error or underrun
// RULE_07 - PHY aborts flagged frame with ABORT symbols
// RULE_08 - Management clock driven, software paced edges
// RULE_09 - Management data line carries PHY transfers
// RULE_10 - PHY raises carrier while medium busy
// RULE_11 - PHY raises collision when detected
// RULE_12 - Each side drives management line only owning
module mtmp_top
   import mtmp_pkg::*;
#(
   parameter int W = NIB_W                       // Nibble width
)(
   input  wire logic         clk_i,              // System clock, 100 MHz
   input  wire logic         rst_i,              // Synchronous reset, high
   input  wire logic         tx_valid_i,         // Source has a nibble
   input  wire logic [W-1:0] tx_data_i,          // Source nibble
   input  wire logic         tx_last_i,          // Nibble ends the frame
   input  wire logic         tx_code_err_i,      // Nibble carries coding error
   output logic              tx_ready_o,         // Nibble taken this cycle if tx_valid_i is high
   output logic              tx_underrun_o,      // Frame aborted for underrun
   input  wire logic         mii_tx_clk_i,       // Transmit clock from PHY
   output logic [W-1:0]      mii_txd_o,          // Transmit nibble
   output logic              mii_tx_en_o,        // Transmit enable
   output logic              tx_abort_flag_out,  // Transmit error to PHY
   input  wire logic         carrier_present_in, // Carrier sense from PHY
   input  wire logic         mii_col_i,          // Collision from PHY
   output logic              carrier_o,          // Registered carrier
   output logic              collision_o,        // Registered collision
   input  wire logic         sw_mdc_i,           // Software clock level
   input  wire logic         sw_mdio_i,          // Software data bit
   input  wire logic         sw_mdio_oe_i,       // Software drive request
   output logic              mii_mdc_o,          // Management clock pin
   input  wire logic         mii_mdio_i,         // Management data in
   output logic              mii_mdio_o,         // Management data out
   output logic              mii_mdio_oe_o,      // Management drive enable
   output logic              mdio_rd_bit_o,      // Bit caught at clock rise
   output logic              mdio_read_phase_o   // PHY owns the line
);

   typedef struct packed {
      logic           tck;      // Sampled PHY clock
      logic           tck_d;    // Previous sample
      mtmp_tx_state_t state;    // Transmit state
      logic [W-1:0]   txd;      // Nibble on pins
      logic           en;       // Enable on pins
      logic           er;       // Error on pins
      logic           urun;     // Underrun seen
      logic           crs;      // Carrier copy
      logic           col;      // Collision copy
   } mtmp_st_t;

   mtmp_st_t st_ff;
   mtmp_st_t nxt_st;
   logic     tck_rise;
   logic     take;

   mtmp_mgmt_if mif ();

   // ----------------------------------------------------------------
   // Management engine
   // ----------------------------------------------------------------
   assign mif.sw_mdc  = sw_mdc_i;
   assign mif.sw_mdio = sw_mdio_i;
   assign mif.sw_oe   = sw_mdio_oe_i;
   assign mif.pin_in  = mii_mdio_i;

   mtmp_mgmt u_mgmt (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .m     (mif.engine)
   );

   assign mii_mdc_o         = mif.mdc;
   assign mii_mdio_o        = mif.mdio;
   assign mii_mdio_oe_o     = mif.mdio_oe;
   assign mdio_rd_bit_o     = mif.rd_bit;
   assign mdio_read_phase_o = mif.read_phase;

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   // The PHY clock is only sampled; a rise seen here paces each nibble
   assign tck_rise   = st_ff.tck & ~st_ff.tck_d;             // RULE_01
   assign take       = tck_rise & tx_valid_i;
   assign tx_ready_o = tck_rise;                             // RULE_03

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.tck   = mii_tx_clk_i;
      nxt_st.tck_d = st_ff.tck;
      nxt_st.crs   = carrier_present_in;                     // RULE_10
      nxt_st.col   = mii_col_i;                              // RULE_11
      if (tck_rise) begin
         nxt_st.urun = 1'b0;
         case (st_ff.state)
            MTMP_IDLE: begin
               // First taken nibble raises enable with it
               nxt_st.txd = take ? tx_data_i : W'(NIB_IDLE); // RULE_02
               nxt_st.en  = take;                            // RULE_04
               nxt_st.er  = take & tx_code_err_i;            // RULE_06
               if (take && !tx_last_i) begin
                  nxt_st.state = MTMP_SEND;
               end
            end
            MTMP_SEND: begin
               nxt_st.en = 1'b1;                             // RULE_04
               if (take) begin
                  nxt_st.txd = tx_data_i;                    // RULE_02
                  nxt_st.er  = tx_code_err_i;                // RULE_06
                  if (tx_last_i) begin
                     nxt_st.state = MTMP_IDLE;
                  end
               end else begin
                  // Source ran dry: flag one nibble, then end the frame
                  nxt_st.txd   = W'(NIB_IDLE);
                  nxt_st.er    = 1'b1;                       // RULE_06
                  nxt_st.urun  = 1'b1;
                  nxt_st.state = MTMP_IDLE;
               end
            end
            default: begin
               nxt_st.state = MTMP_IDLE;
               nxt_st.en    = 1'b0;
               nxt_st.er    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Enable and data leave the same flops so the PHY sees them together
   assign mii_txd_o         = st_ff.txd;                     // RULE_05
   assign mii_tx_en_o       = st_ff.en;
   assign tx_abort_flag_out = st_ff.er & st_ff.en;           // RULE_06
   assign tx_underrun_o     = st_ff.urun;
   assign carrier_o         = st_ff.crs;
   assign collision_o       = st_ff.col;

endmodule
`default_nettype wire
